// file: rtl/ddblc_pkg.sv
// Behaviour
// - raise enable before changing data
// - separate load cycle or delayed strobe
// - strobe on enables, address on select
// - byte enable low at least 60 ns
// - narrower strobes need longer setup, hold
// - 16-bit host may tie load low
// - 8-bit host writes two bytes, holds output
// - synchronous load rides second byte enable
// - separate load strobe low at least 70 ns
// - address line picks upper or lower byte; here separate upper and lower byte enables pick it
// - select strobe 70 ns, setup 60 ns
// - data held 20 ns after gated strobe
// - shared load signal updates many converters
package ddblc_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int BYTE_PULSE_NS = 60;
	localparam int LOAD_PULSE_NS = 70;
	localparam int SETUP_NS = 60;
	localparam int HOLD_NS = 20;
	// least times round up to whole cycles
	localparam int BYTE_CYC = (BYTE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOAD_CYC = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] MODE_WORD = 2'h0;
	localparam logic [1:0] MODE_BYTE_SYNC = 2'h1;
	localparam logic [1:0] MODE_BYTE_LOAD = 2'h2;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [15:0] DATA_RST = 16'h0000;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SETUP = 5'b00010,
		ST_STROBE = 5'b00100,
		ST_HOLD = 5'b01000,
		ST_GAP = 5'b10000
	} ddblc_state_e;

	typedef struct packed {
		logic select_n;
		logic upper_byte_enable_n;
		logic lower_byte_enable_n;
		logic dac_register_load_n;
	} ddblc_ctl_s;

	typedef struct packed {
		ddblc_state_e state;
		logic [1:0] phase;
		logic [3:0] cnt;
		logic [1:0] mode;
		logic [15:0] word;
		ddblc_ctl_s ctl;
		logic [15:0] data;
		logic busy;
		logic done;
	} ddblc_st_s;
endpackage

// file: rtl/ddblc_host.sv
`timescale 1ns/1ps
module ddblc_host (
	input wire logic clk, // 50 MHz clock
	input wire logic srst, // synchronous reset, high
	input wire logic wr_req, // one-cycle write request
	input wire logic [15:0] wr_word, // offset-binary code
	input wire logic [1:0] wr_mode, // word, byte sync, byte+load
	output logic busy, // write in progress
	output logic done, // one-cycle completion pulse
	output logic select_n, // device select
	output logic upper_byte_enable_n, // upper byte strobe
	output logic lower_byte_enable_n, // lower byte strobe
	output logic dac_register_load_n, // converter register load
	output logic [15:0] data_out // data pins
);
	ddblc_pkg::ddblc_st_s s_r;
	ddblc_pkg::ddblc_st_s s_nxt;
	logic last_phase;
	logic [3:0] strobe_len;

	always_comb
	begin
		// phases: byte modes run two or three
		case (s_r.mode)
			ddblc_pkg::MODE_WORD: last_phase = 1'b1;
			ddblc_pkg::MODE_BYTE_SYNC: last_phase = s_r.phase == 2'h1;
			default: last_phase = s_r.phase == 2'h2;
		endcase
		if (s_r.phase == 2'h2)
			strobe_len = 4'(ddblc_pkg::LOAD_CYC);
		else
			strobe_len = 4'(ddblc_pkg::BYTE_CYC);
	end

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.state)
			ddblc_pkg::ST_IDLE:
			begin
				if (wr_req)
				begin
					s_nxt.mode = wr_mode;
					s_nxt.word = wr_word;
					s_nxt.phase = 2'h0;
					s_nxt.busy = 1'b1;
					s_nxt.cnt = ddblc_pkg::CNT_RST;
					// address on select, data set up
					s_nxt.ctl.select_n = 1'b0;
					// close register, word mode may leave it open
					if (wr_mode != ddblc_pkg::MODE_WORD)
						s_nxt.ctl.dac_register_load_n = 1'b1;
					s_nxt.data = (wr_mode == ddblc_pkg::MODE_WORD) ? wr_word
						: {wr_word[7:0], wr_word[7:0]};
					s_nxt.state = ddblc_pkg::ST_SETUP;
				end
			end
			ddblc_pkg::ST_SETUP:
			begin
				// strobe only after data is valid
				if (s_r.cnt == 4'(ddblc_pkg::SETUP_CYC - 1))
				begin
					s_nxt.cnt = ddblc_pkg::CNT_RST;
					s_nxt.state = ddblc_pkg::ST_STROBE;
					if (s_r.mode == ddblc_pkg::MODE_WORD)
					begin
						s_nxt.ctl.upper_byte_enable_n = 1'b0;
						s_nxt.ctl.lower_byte_enable_n = 1'b0;
						s_nxt.ctl.dac_register_load_n = 1'b0;
					end
					else if (s_r.phase == 2'h0)
						s_nxt.ctl.lower_byte_enable_n = 1'b0;
					else if (s_r.phase == 2'h1)
					begin
						s_nxt.ctl.upper_byte_enable_n = 1'b0;
						if (s_r.mode == ddblc_pkg::MODE_BYTE_SYNC)
							s_nxt.ctl.dac_register_load_n = 1'b0;
					end
					else
						s_nxt.ctl.dac_register_load_n = 1'b0;
				end
				else
					s_nxt.cnt = s_r.cnt + 4'h1;
			end
			ddblc_pkg::ST_STROBE:
			begin
				if (s_r.cnt == strobe_len - 4'h1)
				begin
					s_nxt.cnt = ddblc_pkg::CNT_RST;
					s_nxt.state = ddblc_pkg::ST_HOLD;
					s_nxt.ctl.upper_byte_enable_n = 1'b1;
					s_nxt.ctl.lower_byte_enable_n = 1'b1;
					if (s_r.mode != ddblc_pkg::MODE_WORD)
						s_nxt.ctl.dac_register_load_n = 1'b1;
				end
				else
					s_nxt.cnt = s_r.cnt + 4'h1;
			end
			ddblc_pkg::ST_HOLD:
			begin
				if (s_r.cnt == 4'(ddblc_pkg::HOLD_CYC - 1))
				begin
					s_nxt.cnt = ddblc_pkg::CNT_RST;
					if (last_phase)
					begin
						s_nxt.ctl.select_n = 1'b1;
						s_nxt.busy = 1'b0;
						s_nxt.done = 1'b1;
						s_nxt.state = ddblc_pkg::ST_IDLE;
					end
					else
					begin
						s_nxt.phase = s_r.phase + 2'h1;
						if (s_r.phase == 2'h0)
							s_nxt.data = {s_r.word[15:8], s_r.word[15:8]};
						s_nxt.state = ddblc_pkg::ST_SETUP;
					end
				end
				else
					s_nxt.cnt = s_r.cnt + 4'h1;
			end
			default:
				s_nxt.state = ddblc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_r.state <= ddblc_pkg::ST_IDLE;
			s_r.phase <= 2'h0;
			s_r.cnt <= ddblc_pkg::CNT_RST;
			s_r.mode <= ddblc_pkg::MODE_WORD;
			s_r.word <= ddblc_pkg::DATA_RST;
			s_r.ctl <= 4'hF;
			s_r.data <= ddblc_pkg::DATA_RST;
			s_r.busy <= 1'b0;
			s_r.done <= 1'b0;
		end
		else
			s_r <= s_nxt;
	end

	assign busy = s_r.busy;
	assign done = s_r.done;
	assign select_n = s_r.ctl.select_n;
	assign upper_byte_enable_n = s_r.ctl.upper_byte_enable_n;
	assign lower_byte_enable_n = s_r.ctl.lower_byte_enable_n;
	// registered load, fan-out safe for several converters
	assign dac_register_load_n = s_r.ctl.dac_register_load_n;
	assign data_out = s_r.data;

	AST_BYTE_PULSE: assert property (@(posedge clk) disable iff (srst)
		$fell(lower_byte_enable_n) |-> !lower_byte_enable_n [*3])
		else $error("lower byte strobe too short");
	AST_LOAD_PULSE: assert property (@(posedge clk) disable iff (srst)
		$fell(dac_register_load_n) && upper_byte_enable_n
		&& lower_byte_enable_n |-> !dac_register_load_n [*4])
		else $error("load strobe too short");
	AST_DATA_STABLE: assert property (@(posedge clk) disable iff (srst)
		!upper_byte_enable_n || !lower_byte_enable_n |-> $stable(data_out))
		else $error("data moved while enabled");
	AST_HOLD: assert property (@(posedge clk) disable iff (srst)
		$rose(lower_byte_enable_n) |-> $stable(data_out))
		else $error("data changed in hold");
	AST_SELECT: assert property (@(posedge clk) disable iff (srst)
		!upper_byte_enable_n || !lower_byte_enable_n |-> !select_n)
		else $error("strobe without select");
	AST_SYNC: assert property (@(posedge clk) disable iff (srst)
		$fell(upper_byte_enable_n) && s_r.mode == ddblc_pkg::MODE_BYTE_SYNC
		|-> !dac_register_load_n)
		else $error("sync load missing");
	AST_DONE: assert property (@(posedge clk) disable iff (srst)
		$rose(busy) |-> ##[6:40] done)
		else $error("write never completed");
	AST_SETUP: assert property (@(posedge clk) disable iff (srst)
		$fell(lower_byte_enable_n) |-> !$past(select_n, 3))
		else $error("strobe without setup");
	AST_UPPER_PULSE: assert property (@(posedge clk) disable iff (srst)
		$fell(upper_byte_enable_n) |-> !upper_byte_enable_n [*3])
		else $error("upper byte strobe too short");
	AST_LOAD_OFF: assert property (@(posedge clk) disable iff (srst)
		!lower_byte_enable_n && s_r.mode != ddblc_pkg::MODE_WORD
		|-> dac_register_load_n)
		else $error("register open during low byte");
	AST_UP_HOLD: assert property (@(posedge clk) disable iff (srst)
		$rose(upper_byte_enable_n) |-> $stable(data_out))
		else $error("data changed in upper hold");
	AST_WORD_ALL: assert property (@(posedge clk) disable iff (srst)
		$fell(lower_byte_enable_n) && s_r.mode == ddblc_pkg::MODE_WORD
		|-> !upper_byte_enable_n && !dac_register_load_n)
		else $error("word strobes apart");
	AST_IDLE_SEL: assert property (@(posedge clk) disable iff (srst)
		!busy |-> select_n)
		else $error("select low while idle");
	AST_LOAD_SETUP: assert property (@(posedge clk) disable iff (srst)
		$fell(dac_register_load_n) |-> !$past(select_n, 3))
		else $error("load strobe without setup");
endmodule

// file: sim/ddblc_dev_model.sv
`timescale 1ns/1ps
module ddblc_dev_model (
	input wire logic select_n, // device select
	input wire logic upper_byte_enable_n, // upper strobe
	input wire logic lower_byte_enable_n, // lower strobe
	input wire logic dac_register_load_n, // register load
	input wire logic [15:0] data_in, // data pins
	output logic [15:0] code // offset-binary output code
);
	logic [7:0] rank_hi_r;
	logic [7:0] rank_lo_r;
	always_latch
	begin
		if (!select_n && !upper_byte_enable_n)
			rank_hi_r <= data_in[15:8];
	end
	always_latch
	begin
		if (!select_n && !lower_byte_enable_n)
			rank_lo_r <= data_in[7:0];
	end
	always_latch
	begin
		if (!select_n && !dac_register_load_n)
			code <= {rank_hi_r, rank_lo_r};
	end
endmodule

// file: sim/ddblc_host_tb.sv
`timescale 1ns/1ps
module ddblc_host_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic wr_req = 1'b0;
	logic [15:0] wr_word = 16'h0000;
	logic [1:0] wr_mode = 2'h0;
	logic busy, done, select_n, ube_n, lbe_n, load_n;
	logic [15:0] data_out, code;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	ddblc_host i_dut (
		.clk(clk),
		.srst(srst),
		.wr_req(wr_req),
		.wr_word(wr_word),
		.wr_mode(wr_mode),
		.busy(busy),
		.done(done),
		.select_n(select_n),
		.upper_byte_enable_n(ube_n),
		.lower_byte_enable_n(lbe_n),
		.dac_register_load_n(load_n),
		.data_out(data_out)
	);
	ddblc_dev_model i_dev (
		.select_n(select_n),
		.upper_byte_enable_n(ube_n),
		.lower_byte_enable_n(lbe_n),
		.dac_register_load_n(load_n),
		.data_in(data_out),
		.code(code)
	);
	initial
	begin
		forever #10 clk = ~clk;
	end
	task check(input logic [15:0] seen, exp, input string what);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail++;
			finish_test;
		end
	end
	task write(input logic [1:0] mode, input logic [15:0] w, input int lat);
		int n;
		int lo;
		int ld;
		int bz;
		n = 0;
		lo = 0;
		ld = 0;
		bz = 0;
		wr_req = 1'b1;
		wr_word = w;
		wr_mode = mode;
		@(negedge clk);
		while (done !== 1'b1 && n < 40)
		begin
			n++;
			// a stray request while busy must be ignored
			wr_req = (n == 3);
			wr_word = (n == 3) ? ~w : w;
			lo += (lbe_n === 1'b0);
			ld += (load_n === 1'b0 && ube_n === 1'b1);
			bz += (busy !== 1'b1);
			if (mode != 2'h0 && lbe_n === 1'b0)
				check(load_n, 1'b1, "load off on low byte");
			@(negedge clk);
		end
		// loop ran once per edge after the request edge, up to the one that raised done
		check(16'(n + 1), 16'(lat), "latency");
		check(16'(bz), 16'h0000, "busy during write");
		check({busy, done}, 2'h1, "busy done at end");
		check(code, w, "output code");
		check(lo >= ddblc_pkg::BYTE_CYC, 1'b1, "byte strobe width");
		if (mode == 2'h2)
			check(ld >= ddblc_pkg::LOAD_CYC, 1'b1, "load width");
	endtask
	initial
	begin
		repeat (6) @(negedge clk);
		srst = 1'b0;
		check({select_n, ube_n, lbe_n, load_n}, 4'hF, "idle controls");
		check(data_out, 16'h0000, "idle data");
		write(2'h2, 16'hA5C3, 23);
		write(2'h1, 16'h1234, 15);
		write(2'h0, 16'h0000, 8);
		write(2'h0, 16'hFFFF, 8);
		write(2'h1, 16'h8001, 15);
		// reset in mid-strobe; two edges so no false edge follows
		wr_req = 1'b1;
		wr_word = 16'h5A5A;
		wr_mode = 2'h2;
		@(negedge clk);
		wr_req = 1'b0;
		repeat (4) @(negedge clk);
		check(lbe_n, 1'b0, "strobe before reset");
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		check({busy, select_n}, 2'h1, "reset busy select");
		check({ube_n, lbe_n, load_n}, 3'h7, "reset strobes");
		check(data_out, 16'h0000, "data after reset");
		write(2'h1, 16'hC33C, 15);
		finish_test;
	end
endmodule
